// ---- pkg/adc_sar_pkg.sv ----
// constants, register map and types for the sar converter control block
package adc_sar_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int PIN_COUNT = 13;

  localparam logic [2:0] IDX_CONTROL_CHANNEL = 3'h0;
  localparam logic [2:0] IDX_PIN_REF_CONFIG = 3'h1;
  localparam logic [2:0] IDX_TIMING_FORMAT = 3'h2;
  localparam logic [2:0] IDX_RESULT_HIGH = 3'h3;
  localparam logic [2:0] IDX_RESULT_LOW = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MASK_CONTROL_CHANNEL = 8'hbf;
  localparam logic [7:0] MASK_PIN_REF_CONFIG = 8'h3f;
  localparam logic [7:0] MASK_TIMING_FORMAT = 8'hbf;

  localparam int BIT_CALIBRATE_NEXT = 7;
  localparam int BIT_CHAN_LSB = 2;
  localparam int BIT_GO = 1;
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_NEG_REF = 5;
  localparam int BIT_POS_REF = 4;
  localparam int BIT_RESULT_JUSTIFY = 7;
  localparam int BIT_ACQ_LSB = 3;
  localparam int BIT_FLAG = 0;

  localparam logic [3:0] PIN_ALL_ANALOG_MAX = 4'h2;
  localparam logic [3:0] PIN_CODE_BASE = 4'hf;
  localparam logic [12:0] SMALL_PKG_ABSENT = 13'h00e0;

  localparam logic [2:0] CLKSEL_RC_LOW = 3'h3;
  localparam logic [4:0] HOLDOFF_TADS = 5'h02;
  localparam logic [3:0] CONV_LAST_TAD = 4'ha;
  localparam logic [RES_W-1:0] SAR_FIRST_TRIAL = 10'h200;

  // one instruction cycle is four system clocks
  localparam int INSTR_CYCLE_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [2:0] INSTR_CYCLE_CLKS = 3'(INSTR_CYCLE_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RC_DELAY,
    ST_ACQUIRE,
    ST_CONVERT,
    ST_HOLDOFF
  } state_t;
endpackage

// ---- hdl/adc_sar_control.sv ----
// control logic of the 10-bit successive-approximation converter
// Functional notes
// - with calibrate_next set, the next conversion also runs calibration.
// - channel_select codes 0 to 12 route that channel; 13 to 15 are unimplemented.
// - status bit reads one while converting, zero when idle, if enabled.
// - converter_on enables the module; clearing it turns the module off.
// - reference bits pick supply or external pin for negative and positive references.
// - pin_role_config 0 to 2 all analog; each higher code adds one digital pin.
// - result_justify set gives right justified result, clear gives left justified.
// - acquire_length selects 0,2,4,6,8,12,16 or 20 bit periods.
// - conv_clock_select picks system clock divided by 2..64 or the rc clock.
// - rc clock adds one instruction cycle before the bit clock starts.
// - during sleep conversion continues only when clocked from the rc clock.
// - result is resolved by successive approximation, one bit per bit period.
// - reset returns all registers to reset values and aborts any conversion.
// - completion writes result pair, clears status bit, sets conv_done_flag.
// - nonzero acquire length is inserted between start request and conversion.
// - at least two bit periods pass after a conversion before next acquisition.
// - small package has 10 analog inputs, channels 5 to 7 absent.
// - unimplemented control register bits read zero and ignore writes.
// - clearing status bit mid-conversion aborts; result pair stays unchanged.
// - each conversion takes eleven bit periods.
// - after acquisition conversion starts by itself with no phase indication.
`timescale 1ns/1ps
module adc_sar_control
  import adc_sar_pkg::*;
(
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  input  wire logic [adc_sar_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [adc_sar_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [adc_sar_pkg::DATA_W-1:0] rd_data_out,
  input  wire logic                        comp_in,
  input  wire logic                        rc_tick_in,
  input  wire logic                        sleep_in,
  input  wire logic                        small_pkg_in,
  output logic      [3:0]                  channel_select_out,
  output logic      [adc_sar_pkg::PIN_COUNT-1:0] pin_analog_out,
  output logic                             neg_ref_select_out,
  output logic                             pos_ref_select_out,
  output logic                             sample_out,
  output logic                             calibrate_out,
  output logic      [adc_sar_pkg::RES_W-1:0] dac_code_out,
  output logic                             converter_on_out,
  output logic                             conv_done_flag_out
);
  import adc_sar_pkg::*;

  typedef struct packed {
    state_t                 state;
    logic [7:0]             ctrl;
    logic [7:0]             pincfg;
    logic [7:0]             timing;
    logic [7:0]             res_hi;
    logic [7:0]             res_lo;
    logic                   flag;
    logic [5:0]             presc;
    logic [4:0]             tad_cnt;
    logic [3:0]             conv_cnt;
    logic [2:0]             delay_cnt;
    logic [RES_W-1:0]       sar;
    logic [7:0]             rd_data;
    logic                   sample;
    logic                   cal;
    logic [PIN_COUNT-1:0]   analog;
  } regs_t;

  regs_t st_reg;
  regs_t st_next;

  // prescaler terminal count for a divided bit clock
  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    div_limit = 6'h01;
      3'h1:    div_limit = 6'h07;
      3'h2:    div_limit = 6'h1f;
      3'h4:    div_limit = 6'h03;
      3'h5:    div_limit = 6'h0f;
      3'h6:    div_limit = 6'h3f;
      default: div_limit = 6'h00;
    endcase
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0c;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == CLKSEL_RC_LOW[1:0]);
  endfunction

  // code n above 2 turns the top n-2 pins digital
  function automatic logic [PIN_COUNT-1:0] pin_mask(input logic [3:0] code,
                                                    input logic       small_pkg);
    logic [PIN_COUNT-1:0] m;
    logic [3:0]           lim;
    m   = '0;
    lim = PIN_CODE_BASE - code;
    for (int i = 0; i < PIN_COUNT; i++) begin
      m[i] = (code <= PIN_ALL_ANALOG_MAX) || (4'(i) < lim);
    end
    if (small_pkg) begin
      m = m & ~SMALL_PKG_ABSENT;
    end
    pin_mask = m;
  endfunction

  logic       on_bit;
  logic       go_bit;
  logic [2:0] clk_sel;
  logic [2:0] acq_sel;
  logic       rc_sel;
  logic       tick;
  logic       presc_run;
  logic [3:0] bit_idx;

  always_comb begin
    on_bit  = st_reg.ctrl[BIT_CONVERTER_ON];
    go_bit  = st_reg.ctrl[BIT_GO];
    clk_sel = st_reg.timing[2:0];
    acq_sel = st_reg.timing[BIT_ACQ_LSB +: 3];
    rc_sel  = is_rc(clk_sel);
    bit_idx = CONV_LAST_TAD - st_reg.conv_cnt;
    // system clock stops in sleep, so only the rc clock keeps ticking
    presc_run = (st_reg.state == ST_ACQUIRE) || (st_reg.state == ST_CONVERT)
                || (st_reg.state == ST_HOLDOFF);
    if (rc_sel) begin
      tick = presc_run && rc_tick_in;
    end else begin
      tick = presc_run && !sleep_in && (st_reg.presc == div_limit(clk_sel));
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.rd_data = '0;

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        IDX_CONTROL_CHANNEL: begin
          // go may only be raised once the module was already on
          st_next.ctrl = wr_data_in & MASK_CONTROL_CHANNEL;
          st_next.ctrl[BIT_GO] = wr_data_in[BIT_GO] && (go_bit || on_bit);
        end
        IDX_PIN_REF_CONFIG: st_next.pincfg = wr_data_in & MASK_PIN_REF_CONFIG;
        IDX_TIMING_FORMAT:  st_next.timing = wr_data_in & MASK_TIMING_FORMAT;
        IDX_RESULT_HIGH:    st_next.res_hi = wr_data_in;
        IDX_RESULT_LOW:     st_next.res_lo = wr_data_in;
        IDX_STATUS: begin
          if (!wr_data_in[BIT_FLAG]) begin
            st_next.flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // prescaler restarts on every bit tick and is held at zero outside the clocked phases
    if (tick || !presc_run) begin
      st_next.presc = '0;
    end else if (!sleep_in) begin
      st_next.presc = st_reg.presc + 6'h01;
    end

    unique case (st_reg.state)
      ST_IDLE: begin
        if (on_bit && st_next.ctrl[BIT_GO]) begin
          st_next.tad_cnt = '0;
          st_next.conv_cnt = '0;
          st_next.delay_cnt = '0;
          if (rc_sel) begin
            st_next.state = ST_RC_DELAY;
          end else if (acq_tads(acq_sel) != 5'h00) begin
            st_next.state = ST_ACQUIRE;
          end else begin
            st_next.state = ST_CONVERT;
          end
        end
      end
      ST_RC_DELAY: begin
        st_next.delay_cnt = st_reg.delay_cnt + 3'h1;
        if (st_reg.delay_cnt == INSTR_CYCLE_CLKS - 3'h1) begin
          st_next.state = (acq_tads(acq_sel) != 5'h00) ? ST_ACQUIRE : ST_CONVERT;
        end
      end
      ST_ACQUIRE: begin
        if (tick) begin
          st_next.tad_cnt = st_reg.tad_cnt + 5'h01;
          if (st_reg.tad_cnt + 5'h01 >= acq_tads(acq_sel)) begin
            st_next.state = ST_CONVERT;
            st_next.tad_cnt = '0;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          st_next.conv_cnt = st_reg.conv_cnt + 4'h1;
          if (st_reg.conv_cnt == 4'h0) begin
            st_next.sar = SAR_FIRST_TRIAL;
          end else begin
            // keep the trial bit only if the input is at or above it
            if (!comp_in) begin
              st_next.sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              st_next.sar[bit_idx - 4'h1] = 1'b1;
            end
          end
          if (st_reg.conv_cnt == CONV_LAST_TAD) begin
            st_next.state = ST_HOLDOFF;
            st_next.tad_cnt = '0;
            st_next.ctrl[BIT_GO] = 1'b0;
            st_next.flag = 1'b1;
            if (st_reg.timing[BIT_RESULT_JUSTIFY]) begin
              {st_next.res_hi, st_next.res_lo} = {6'h00, st_next.sar};
            end else begin
              {st_next.res_hi, st_next.res_lo} = {st_next.sar, 6'h00};
            end
          end
        end
      end
      ST_HOLDOFF: begin
        if (tick) begin
          st_next.tad_cnt = st_reg.tad_cnt + 5'h01;
          if (st_reg.tad_cnt + 5'h01 >= HOLDOFF_TADS) begin
            st_next.state = ST_IDLE;
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // software clearing go abandons the sequence without touching the result
    if ((st_reg.state == ST_RC_DELAY || st_reg.state == ST_ACQUIRE
         || st_reg.state == ST_CONVERT) && !st_next.ctrl[BIT_GO]
        && st_next.state != ST_HOLDOFF) begin
      st_next.state = ST_HOLDOFF;
      st_next.tad_cnt = '0;
    end

    if (!st_next.ctrl[BIT_CONVERTER_ON]) begin
      st_next.state = ST_IDLE;
      st_next.ctrl[BIT_GO] = 1'b0;
    end

    // reads answer in the following cycle only
    if (rd_in) begin
      unique case (addr_in)
        IDX_CONTROL_CHANNEL: begin
          st_next.rd_data = st_reg.ctrl;
          st_next.rd_data[BIT_GO] = go_bit && on_bit;
        end
        IDX_PIN_REF_CONFIG: st_next.rd_data = st_reg.pincfg;
        IDX_TIMING_FORMAT:  st_next.rd_data = st_reg.timing;
        IDX_RESULT_HIGH:    st_next.rd_data = st_reg.res_hi;
        IDX_RESULT_LOW:     st_next.rd_data = st_reg.res_lo;
        IDX_STATUS:         st_next.rd_data = {7'h00, st_reg.flag};
        default:            st_next.rd_data = '0;
      endcase
    end

    st_next.sample = st_next.ctrl[BIT_CONVERTER_ON] && (st_next.state != ST_CONVERT);
    st_next.cal = st_next.ctrl[BIT_CALIBRATE_NEXT] && (st_next.state == ST_CONVERT);
    st_next.analog = pin_mask(st_next.pincfg[3:0], small_pkg_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    rd_data_out        = st_reg.rd_data;
    channel_select_out = st_reg.ctrl[BIT_CHAN_LSB +: 4];
    pin_analog_out     = st_reg.analog;
    neg_ref_select_out = st_reg.pincfg[BIT_NEG_REF];
    pos_ref_select_out = st_reg.pincfg[BIT_POS_REF];
    sample_out         = st_reg.sample;
    calibrate_out      = st_reg.cal;
    dac_code_out       = st_reg.sar;
    converter_on_out   = st_reg.ctrl[BIT_CONVERTER_ON];
    conv_done_flag_out = st_reg.flag;
  end
endmodule

// ---- testbench/adc_sar_control_sva.sv ----
// port assertions for the sar converter control block
`timescale 1ns/1ps
module adc_sar_control_sva
  import adc_sar_pkg::*;
(
  input wire logic                                sys_clk_in,
  input wire logic                                rst_n_in,
  input wire logic                                ce_in,
  input wire logic [adc_sar_pkg::ADDR_W-1:0]      addr_in,
  input wire logic [adc_sar_pkg::DATA_W-1:0]      wr_data_in,
  input wire logic                                wr_in,
  input wire logic                                rd_in,
  input wire logic [adc_sar_pkg::DATA_W-1:0]      rd_data_out,
  input wire logic                                small_pkg_in,
  input wire logic [3:0]                          channel_select_out,
  input wire logic [adc_sar_pkg::PIN_COUNT-1:0]   pin_analog_out,
  input wire logic                                neg_ref_select_out,
  input wire logic                                pos_ref_select_out,
  input wire logic                                sample_out,
  input wire logic                                calibrate_out,
  input wire logic                                converter_on_out
);
  logic                 wr_ctl;
  logic                 wr_pin;
  logic [PIN_COUNT-1:0] pin_exp;
  // pins turn digital from the top channel down once the code passes the all-analog range
  always_comb begin
    wr_ctl = ce_in && wr_in && addr_in == IDX_CONTROL_CHANNEL;
    wr_pin = ce_in && wr_in && addr_in == IDX_PIN_REF_CONFIG;
    pin_exp = 13'h1fff;
    if (wr_data_in[3:0] > PIN_ALL_ANALOG_MAX) pin_exp = 13'h1fff >> (wr_data_in[3:0] - 4'h2);
    if (small_pkg_in) pin_exp = pin_exp & ~SMALL_PKG_ABSENT;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_on;
    wr_ctl |=> converter_on_out == $past(wr_data_in[BIT_CONVERTER_ON]);
  endproperty
  a_on: assert property (p_on) else $error("enable output did not follow write");
  property p_chan;
    wr_ctl |=> channel_select_out == $past(wr_data_in[5:2]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel output did not follow write");
  property p_ref;
    wr_pin |=> {neg_ref_select_out, pos_ref_select_out} == $past(wr_data_in[5:4]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference outputs wrong");
  property p_pin;
    wr_pin |=> pin_analog_out == $past(pin_exp);
  endproperty
  a_pin: assert property (p_pin) else $error("pin roles wrong after config write");
  property p_rd_idle;
    ce_in && !rd_in |=> rd_data_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmapped;
    ce_in && rd_in && addr_in > IDX_STATUS |=> rd_data_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
  property p_rsv;
    ce_in && rd_in && addr_in == IDX_PIN_REF_CONFIG |=> rd_data_out[7:6] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unimplemented bits read nonzero");
  property p_cal;
    calibrate_out |-> converter_on_out && !sample_out;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration outside conversion");
endmodule
bind adc_sar_control adc_sar_control_sva i_adc_sar_control_sva (.*);

// ---- testbench/adc_sar_analog_model.sv ----
// analog side stand-in: sample-and-hold, comparator and rc oscillator
`timescale 1ns/1ps
module adc_sar_analog_model #(
  parameter int RC_PERIOD = 6
) (
  input  wire logic       sys_clk_in,
  input  wire logic       sample_in,
  input  wire logic [9:0] level_in,
  input  wire logic [9:0] dac_code_in,
  output logic            comp_out,
  output logic            rc_tick_out
);
  logic [9:0] held_reg = 10'h000;
  int         rc_cnt = 0;
  // hold freezes while converting so a moving input cannot skew the trials
  always @(posedge sys_clk_in) begin
    if (sample_in) held_reg <= level_in;
    rc_cnt <= (rc_cnt == RC_PERIOD - 1) ? 0 : rc_cnt + 1;
  end
  assign comp_out = held_reg >= dac_code_in;
  assign rc_tick_out = rc_cnt == 0;
endmodule

// ---- testbench/test_adc_sar_control.sv ----
// self-checking bench for the sar converter control block
`timescale 1ns/1ps
module test_adc_sar_control;
  import adc_sar_pkg::*;
  localparam int RCP = 6;
  logic              sys_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              wr_in = 1'b0;
  logic              rd_in = 1'b0;
  logic              sleep_in = 1'b0;
  logic              small_pkg_in = 1'b0;
  logic              cal_seen = 1'b0;
  logic [2:0]        addr_in = 3'h0;
  logic [7:0]        wr_data_in = 8'h00;
  logic [7:0]        rd_data_out;
  logic [9:0]        level = 10'h000;
  logic [9:0]        dac_code;
  logic [12:0]       pins;
  logic [3:0]        chan;
  logic              comp, rc_tick, sample, cal, neg_ref, pos_ref, conv_on, flag;
  int                num_errors = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                t0;
  int                divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int                acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  adc_sar_control i_adc_sar_control (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .comp_in(comp), .rc_tick_in(rc_tick), .sleep_in(sleep_in),
    .small_pkg_in(small_pkg_in), .channel_select_out(chan), .pin_analog_out(pins),
    .neg_ref_select_out(neg_ref), .pos_ref_select_out(pos_ref), .sample_out(sample),
    .calibrate_out(cal), .dac_code_out(dac_code), .converter_on_out(conv_on),
    .conv_done_flag_out(flag));
  adc_sar_analog_model #(.RC_PERIOD(RCP)) i_adc_sar_analog_model (.sys_clk_in(sys_clk_in),
    .sample_in(sample), .level_in(level), .dac_code_in(dac_code), .comp_out(comp),
    .rc_tick_out(rc_tick));
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cal === 1'b1) cal_seen <= 1'b1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    // read data stand until this edge updates the registers, so it is still the answer here
    @(posedge sys_clk_in);
    check8(what, exp, rd_data_out);
  endtask
  task automatic zero_reads();
    for (int a = 0; a < 8; a++) reg_rd(3'(a), 8'h00, "reset value");
  endtask
  task automatic conv_run(input int i);
    logic [9:0] res;
    logic [7:0] ctl;
    int         per;
    int         e;
    res = 10'h3ff - 10'(i * 93);
    per = (divs[i] == 0) ? RCP : divs[i];
    e = per * (11 + acqs[i]) + ((divs[i] == 0) ? int'(INSTR_CYCLE_CLKS) : 0);
    ctl = {i[1], 1'b0, 4'(i + 5), 2'b01};
    reg_wr(IDX_TIMING_FORMAT, {i[0], 1'b0, 3'(i), 3'(i)});
    reg_wr(IDX_CONTROL_CHANNEL, ctl);
    level <= res;
    sleep_in <= (divs[i] == 0);
    cal_seen <= 1'b0;
    reg_wr(IDX_CONTROL_CHANNEL, ctl | 8'h02);
    t0 = cyc;
    reg_rd(IDX_CONTROL_CHANNEL, ctl | 8'h02, "busy status");
    while (flag !== 1'b1 && cyc - t0 < 3000) @(posedge sys_clk_in);
    // the free running rc tick may land up to one period early against the start request
    check_rng("cycles", e - 2 - ((divs[i] == 0) ? per : 0), e + 6 + ((divs[i] == 0) ? per : 0),
              cyc - t0);
    reg_rd(IDX_CONTROL_CHANNEL, ctl, "done status");
    reg_rd(IDX_RESULT_HIGH, i[0] ? {6'h00, res[9:8]} : res[9:2], "result high");
    reg_rd(IDX_RESULT_LOW, i[0] ? res[7:0] : {res[1:0], 6'h00}, "result low");
    reg_rd(IDX_STATUS, 8'h01, "done flag");
    reg_wr(IDX_STATUS, 8'h00);
    reg_rd(IDX_STATUS, 8'h00, "flag cleared");
    check8("calibration", {7'h00, i[1]}, {7'h00, cal_seen});
    sleep_in <= 1'b0;
    repeat (150) @(posedge sys_clk_in);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    zero_reads();
    reg_wr(IDX_CONTROL_CHANNEL, 8'hfd);
    reg_rd(IDX_CONTROL_CHANNEL, 8'hbd, "control bits");
    reg_wr(IDX_PIN_REF_CONFIG, 8'hff);
    reg_rd(IDX_PIN_REF_CONFIG, 8'h3f, "pin config bits");
    reg_wr(IDX_TIMING_FORMAT, 8'hff);
    reg_rd(IDX_TIMING_FORMAT, 8'hbf, "timing bits");
    reg_wr(3'h7, 8'hff);
    reg_rd(3'h7, 8'h00, "unmapped index");
    reg_wr(IDX_CONTROL_CHANNEL, 8'h00);
    for (int c = 0; c < 16; c++) begin
      small_pkg_in <= (c > 11);
      reg_wr(IDX_PIN_REF_CONFIG, 8'(c * 17) & 8'h3f);
      reg_rd(IDX_PIN_REF_CONFIG, 8'(c * 17) & 8'h3f, "pin config");
    end
    small_pkg_in <= 1'b0;
    reg_wr(IDX_PIN_REF_CONFIG, 8'h00);
    for (int i = 0; i < 8; i++) conv_run(i);
    level <= 10'h0aa;
    reg_wr(IDX_TIMING_FORMAT, 8'h06);
    reg_wr(IDX_CONTROL_CHANNEL, 8'h03);
    repeat (200) @(posedge sys_clk_in);
    reg_wr(IDX_CONTROL_CHANNEL, 8'h01);
    repeat (300) @(posedge sys_clk_in);
    reg_rd(IDX_STATUS, 8'h00, "abort flag");
    reg_rd(IDX_RESULT_HIGH, 8'h01, "abort result high");
    reg_rd(IDX_RESULT_LOW, 8'h74, "abort result low");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    zero_reads();
    print_verdict();
  end
endmodule
